// ===== logic/sso_pkg.sv
// sso_pkg: register map, field positions, reset values and timing of the
// servo status output logic.
// assumes a 32-bit APB slave port on a 125 MHz system clock.
package sso_pkg;

  // register byte offsets
  localparam logic [7:0] ROT_LEVEL_OFS  = 8'h00;
  localparam logic [7:0] OUT_SEL1_OFS   = 8'h04;
  localparam logic [7:0] OUT_SEL2_OFS   = 8'h08;
  localparam logic [7:0] CODE_CFG_OFS   = 8'h0C;
  localparam logic [7:0] STATUS_OFS     = 8'h10;

  // rotation detection level, r/min
  localparam int          ROT_LEVEL_W   = 14;
  localparam logic [13:0] ROT_LEVEL_MIN = 14'h0001;
  localparam logic [13:0] ROT_LEVEL_MAX = 14'h2710;   // 10000
  localparam logic [13:0] ROT_LEVEL_RST = 14'h0014;   // 20

  // output selection words, four 4-bit digits each
  localparam logic [15:0] OUT_SEL1_RST  = 16'h3211;
  localparam logic [15:0] OUT_SEL2_RST  = 16'h0000;
  localparam int          RUN_DIGIT     = 2;          // running flag digit
  localparam int          RDY_DIGIT     = 3;          // ready flag digit
  localparam int          WARN_DIGIT    = 3;          // warning flag digit

  // code configuration register fields
  localparam int          WCODE_BIT     = 0;          // warning code select
  localparam int          ABS_BIT       = 1;          // absolute encoder
  localparam logic        WCODE_RST     = 1'b0;
  localparam logic        ABS_RST       = 1'b0;

  // status register fields
  localparam int          ST_RUN_BIT    = 0;
  localparam int          ST_RDY_BIT    = 1;
  localparam int          ST_WARN_BIT   = 2;
  localparam int          ST_CIRC_LSB   = 3;          // three circuit states

  // three-bit warning codes, bit0 = code line one
  localparam logic [2:0]  CODE_OVERLOAD = 3'h1;
  localparam logic [2:0]  CODE_REGEN    = 3'h2;
  localparam logic [2:0]  CODE_NONE     = 3'h0;

  // control cycle timing
  localparam int          CLK_PERIOD_PS = 8000;
  localparam int          CTRL_CYCLE_NS = 8000;
  localparam int          CTRL_CYCLES   = (CTRL_CYCLE_NS * 1000) / CLK_PERIOD_PS;

endpackage : sso_pkg

// ===== logic/sso_speed_detect.sv
// sso_speed_detect: compares motor speed magnitude with the rotation level.
// assumes a one-cycle control tick from the parent's divider.
`timescale 1ns/10ps
module sso_speed_detect #(
  parameter int SPEED_W = 16,
  parameter int LEVEL_W = 14
) (
  input  wire logic               clk_sys,
  input  wire logic               reset,
  input  wire logic               ctrlTick,
  input  wire logic [SPEED_W-1:0] motorSpeed,
  input  wire logic [LEVEL_W-1:0] rotLevel,
  output logic                    running
);
  import sso_pkg::*;

  logic [SPEED_W-1:0] speedMag;
  logic               aboveLevel;
  logic               running_ff;

  // magnitude of a two's complement speed
  assign speedMag   = motorSpeed[SPEED_W-1] ? SPEED_W'(-motorSpeed)
                                            : motorSpeed;
  assign aboveLevel = speedMag > SPEED_W'(rotLevel);

  // flag refreshed once per control cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      running_ff <= 1'b0;
    end else if (ctrlTick) begin
      running_ff <= aboveLevel;
    end
  end

  assign running = running_ff;

endmodule : sso_speed_detect

// ===== logic/sso_status_out.sv
// sso_status_out: running, ready and warning flags, their allocation to the
// three output circuits, and the three-line code output, behind APB.
// assumes synchronous inputs, one 125 MHz clock, synchronous reset.
`timescale 1ns/10ps

// What this block does
// - running flag on while speed above rotation level, off otherwise
// - rotation level in r/min, 1 to 10000, default 20
// - running also shown in status display and monitor item
// - first output select defaults 3211: running circuit 2, ready 3
// - ready only when no alarm and main power on
// - absolute encoder: ready also needs data request high and data sent
// - ready also needs servo enable received
// - warning flag on during overload or regenerative overload warning
// - second output select defaults 0000, warning routed nowhere
// - warning digit 0 routes nowhere, 1 to 3 pick circuit
// - flags sharing a circuit are ORed
// - code select 0 default: code lines carry alarm codes only
// - code select 1: warning codes, alarm code wins when alarm
// - overload code line one; regenerative overload code line two
module sso_status_out #(
  parameter int SPEED_W     = 16,
  parameter int CTRL_CYCLES = sso_pkg::CTRL_CYCLES
) (
  input  wire logic               clk_sys,
  input  wire logic               reset,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  // drive state
  input  wire logic [SPEED_W-1:0] motorSpeed,
  input  wire logic               alarmPresent,
  input  wire logic [2:0]         alarmCode,
  input  wire logic               mainPowerOn,
  input  wire logic               servoEnable,
  input  wire logic               absDataRequest,
  input  wire logic               absDataSent,
  input  wire logic               overloadWarn,
  input  wire logic               regenOverloadWarn,
  // outputs to the host, active low
  output logic [2:0]              outCircuit_n,
  output logic                    codeLineOne_n,
  output logic                    codeLineTwo_n,
  output logic                    codeLineThree_n,
  // status display and monitor item
  output logic                    statusRunning,
  output logic                    runningMonitorItem
);
  import sso_pkg::*;

  localparam int CNT_W = $clog2(CTRL_CYCLES + 1);

  // configuration registers
  logic [ROT_LEVEL_W-1:0] rotLevel_ff;
  logic [15:0]            outSelOne_ff;
  logic [15:0]            outSelTwo_ff;
  logic                   warnCodeSel_ff;
  logic                   absMode_ff;

  // bus state
  logic        pready_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;

  // flags and pins
  logic [CNT_W-1:0] ctrlCnt_ff;
  logic             ctrlTick_ff;
  logic             running;
  logic             ready_ff;
  logic             warning_ff;
  logic [2:0]       outCircuit_n_ff;
  logic [2:0]       codeLine_n_ff;
  logic             statusRunning_ff;
  logic             monitorItem_ff;

  // true when a digit routes its flag to circuit idx (0-based)
  function automatic logic routeHit(input logic [3:0] digit,
                                    input int         idx);
    routeHit = (digit == 4'(idx + 1));
  endfunction : routeHit

  // pick one 4-bit digit from a selection word
  function automatic logic [3:0] digitOf(input logic [15:0] word,
                                         input int          pos);
    digitOf = word[pos*4 +: 4];
  endfunction : digitOf

  // apb decode
  wire setupPhase = psel && !penable;
  wire writeDone  = psel && penable && pready_ff && pwrite;
  wire hitLevel   = (paddr == ROT_LEVEL_OFS);
  wire hitSelOne  = (paddr == OUT_SEL1_OFS);
  wire hitSelTwo  = (paddr == OUT_SEL2_OFS);
  wire hitCodeCfg = (paddr == CODE_CFG_OFS);
  wire hitStatus  = (paddr == STATUS_OFS);
  wire addrValid  = hitLevel || hitSelOne || hitSelTwo || hitCodeCfg
                    || hitStatus;
  wire [ROT_LEVEL_W-1:0] wrLevel = pwdata[ROT_LEVEL_W-1:0];
  wire levelInRange = (pwdata[31:ROT_LEVEL_W] == '0)
                      && (wrLevel >= ROT_LEVEL_MIN)
                      && (wrLevel <= ROT_LEVEL_MAX);
  // out-of-range level or status write is answered with an error
  wire badWrite   = pwrite && ((hitLevel && !levelInRange) || hitStatus);
  wire errNow     = !addrValid || badWrite;

  // read multiplexer
  wire [31:0] statusWord = {26'h0000000, ~outCircuit_n_ff, warning_ff,
                            ready_ff, running};
  wire [31:0] rdMux =
      hitLevel   ? {18'h00000, rotLevel_ff} :
      hitSelOne  ? {16'h0000, outSelOne_ff} :
      hitSelTwo  ? {16'h0000, outSelTwo_ff} :
      hitCodeCfg ? {30'h00000000, absMode_ff, warnCodeSel_ff} :
      hitStatus  ? statusWord : 32'h00000000;

  // answer prepared in setup, given in the single access cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setupPhase;
      prdata_ff  <= (setupPhase && !pwrite) ? rdMux : 32'h00000000;
      pslverr_ff <= setupPhase && errNow;
    end
  end

  // configuration writes, committed at the completing edge
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rotLevel_ff    <= ROT_LEVEL_RST;
      outSelOne_ff   <= OUT_SEL1_RST;
      outSelTwo_ff   <= OUT_SEL2_RST;
      warnCodeSel_ff <= WCODE_RST;
      absMode_ff     <= ABS_RST;
    end else if (writeDone && !pslverr_ff) begin
      if (hitLevel)   rotLevel_ff  <= wrLevel;
      if (hitSelOne)  outSelOne_ff <= pwdata[15:0];
      if (hitSelTwo)  outSelTwo_ff <= pwdata[15:0];
      if (hitCodeCfg) begin
        warnCodeSel_ff <= pwdata[WCODE_BIT];
        absMode_ff     <= pwdata[ABS_BIT];
      end
    end
  end

  // control cycle divider, one-cycle tick
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrlCnt_ff  <= '0;
      ctrlTick_ff <= 1'b0;
    end else begin
      ctrlTick_ff <= (ctrlCnt_ff == CNT_W'(CTRL_CYCLES - 1));
      ctrlCnt_ff  <= (ctrlCnt_ff == CNT_W'(CTRL_CYCLES - 1))
                     ? '0 : ctrlCnt_ff + 1'b1;
    end
  end

  // speed magnitude against rotation level
  sso_speed_detect #(
    .SPEED_W (SPEED_W),
    .LEVEL_W (ROT_LEVEL_W)
  ) u_speed_detect (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .ctrlTick   (ctrlTick_ff),
    .motorSpeed (motorSpeed),
    .rotLevel   (rotLevel_ff),
    .running    (running)
  );

  // ready and warning conditions
  wire absOk   = !absMode_ff || (absDataRequest && absDataSent);
  wire readyOk = !alarmPresent && mainPowerOn
                 && servoEnable && absOk;
  wire warnOk  = overloadWarn || regenOverloadWarn;

  // circuit allocation, ORed per circuit
  wire [3:0] runDigit  = digitOf(outSelOne_ff, RUN_DIGIT);
  wire [3:0] rdyDigit  = digitOf(outSelOne_ff, RDY_DIGIT);
  wire [3:0] warnDigit = digitOf(outSelTwo_ff, WARN_DIGIT);
  logic [2:0] circuitOn;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      circuitOn[i] = (running    && routeHit(runDigit, i))
                   || (ready_ff   && routeHit(rdyDigit, i))
                   || (warning_ff && routeHit(warnDigit, i));
    end
  end

  // code line selection, alarm has priority over warnings
  wire [2:0] warnCode = overloadWarn      ? CODE_OVERLOAD :
                        regenOverloadWarn ? CODE_REGEN : CODE_NONE;
  wire [2:0] nxt_code = alarmPresent   ? alarmCode :
                        warnCodeSel_ff ? warnCode : CODE_NONE;

  // registered flags and pins
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ready_ff         <= 1'b0;
      warning_ff       <= 1'b0;
      outCircuit_n_ff  <= 3'h7;       // pins idle high
      codeLine_n_ff    <= 3'h7;
      statusRunning_ff <= 1'b0;
      monitorItem_ff   <= 1'b0;
    end else begin
      ready_ff         <= readyOk;
      warning_ff       <= warnOk;
      outCircuit_n_ff  <= ~circuitOn;
      codeLine_n_ff    <= ~nxt_code;
      statusRunning_ff <= running;
      monitorItem_ff   <= running;
    end
  end

  // port drive, pins are active low
  assign pready             = pready_ff;
  assign prdata             = prdata_ff;
  assign pslverr            = pslverr_ff;
  assign outCircuit_n       = outCircuit_n_ff;
  assign codeLineOne_n      = codeLine_n_ff[0];
  assign codeLineTwo_n      = codeLine_n_ff[1];
  assign codeLineThree_n    = codeLine_n_ff[2];
  assign statusRunning      = statusRunning_ff;
  assign runningMonitorItem = monitorItem_ff;

endmodule : sso_status_out

// ===== verif/sso_status_out_asserts.sv
// sso_status_out_asserts: port-level checks of the status output block.
// assumes a bind onto sso_status_out, handing on its parameters.
`timescale 1ns/10ps
module sso_status_out_asserts #(
  parameter int SPEED_W     = 16,
  parameter int CTRL_CYCLES = 4
) (
  input wire logic               clk_sys,
  input wire logic               reset,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pready,
  input wire logic [31:0]        prdata,
  input wire logic               pslverr,
  input wire logic [SPEED_W-1:0] motorSpeed,
  input wire logic               alarmPresent,
  input wire logic [2:0]         alarmCode,
  input wire logic               mainPowerOn,
  input wire logic               overloadWarn,
  input wire logic               regenOverloadWarn,
  input wire logic [2:0]         outCircuit_n,
  input wire logic               codeLineOne_n,
  input wire logic               codeLineTwo_n,
  input wire logic               codeLineThree_n,
  input wire logic               statusRunning,
  input wire logic               runningMonitorItem
);
  logic [15:0] quietCnt_ff;
  logic        quiet;
  default clocking @(posedge clk_sys); endclocking
  default disable iff reset;
  // every flag cause idle: no power, no warning, motor at rest
  assign quiet = !mainPowerOn && !overloadWarn && !regenOverloadWarn &&
                 motorSpeed == '0;
  // idle cycle count, saturating
  always_ff @(posedge clk_sys) begin
    if (reset || !quiet) quietCnt_ff <= '0;
    else if (quietCnt_ff != 16'hFFFF) quietCnt_ff <= quietCnt_ff + 16'h0001;
  end
  sequence apbSetup; psel && !penable; endsequence
  sequence apbAnswer; pready ##1 !pready; endsequence
  a_setup_answered: assert property (apbSetup |=> apbAnswer)
    else $error("setup not answered in one access cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not cleared");
  a_alarm_code_wins: assert property (alarmPresent |=>
    {codeLineThree_n, codeLineTwo_n, codeLineOne_n} == ~$past(alarmCode))
    else $error("alarm code not on code lines");
  a_overload_code: assert property (!alarmPresent && overloadWarn |=>
    codeLineTwo_n && codeLineThree_n) else $error("overload code wrong");
  a_quiet_outputs: assert property (
    quietCnt_ff > 16'(CTRL_CYCLES + 3) |-> outCircuit_n == 3'h7 &&
    !statusRunning) else $error("circuit on with every cause idle");
  a_status_pair: assert property (
    statusRunning == runningMonitorItem) else $error("indications differ");
endmodule : sso_status_out_asserts
bind sso_status_out sso_status_out_asserts #(
  .SPEED_W(SPEED_W), .CTRL_CYCLES(CTRL_CYCLES)) sso_status_out_asserts_inst (
  .clk_sys, .reset, .psel, .penable, .pready, .prdata, .pslverr, .motorSpeed,
  .alarmPresent, .alarmCode, .mainPowerOn, .overloadWarn, .regenOverloadWarn,
  .outCircuit_n, .codeLineOne_n, .codeLineTwo_n, .codeLineThree_n,
  .statusRunning, .runningMonitorItem);

// ===== verif/sso_host_model.sv
// sso_host_model: host controller reading the active-low interlocks.
// assumes the drive's clock; raises the absolute-data request on command.
`timescale 1ns/10ps
module sso_host_model (
  input  wire logic       clk_sys,
  input  wire logic       wantAbs,
  input  wire logic [2:0] outCircuit_n,
  input  wire logic       codeLineOne_n,
  input  wire logic       codeLineTwo_n,
  input  wire logic       codeLineThree_n,
  output logic            absDataRequest,
  output logic [2:0]      circuitOn,
  output logic [2:0]      codeOn
);
  initial absDataRequest = 1'b0;
  // request held steadily high while absolute data is wanted
  always @(posedge clk_sys) absDataRequest <= wantAbs;
  // low level reads as ON at every interlock
  always @(posedge clk_sys) begin
    circuitOn <= ~outCircuit_n;
    codeOn    <= ~{codeLineThree_n, codeLineTwo_n, codeLineOne_n};
  end
endmodule : sso_host_model

// ===== verif/sso_status_out_test.sv
// sso_status_out_test: self-checking bench for the status output block.
// assumes the control cycle shortened to 4 clocks; host model reads pins.
`timescale 1ns/10ps
module sso_status_out_test;
  import sso_pkg::*;
  localparam int CTRL = 4;
  typedef struct {logic look; logic [32:0] val;} sso_note_t;
  logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, look;
  logic alarmPresent, mainPowerOn, servoEnable, absDataRequest, absDataSent;
  logic overloadWarn, regenOverloadWarn, wantAbs, statusRunning;
  logic codeLineOne_n, codeLineTwo_n, codeLineThree_n, runningMonitorItem;
  logic run, rdy, warn;
  logic [2:0]  alarmCode, outCircuit_n, circuitOn, codeOn, on, code;
  logic [7:0]  paddr;
  logic [15:0] motorSpeed;
  logic [31:0] pwdata, prdata, rng;
  logic [32:0] got;
  sso_note_t   nt;
  sso_note_t   notes[$];
  int          errTotal, compares;
  sso_status_out #(.SPEED_W(16), .CTRL_CYCLES(CTRL)) sso_status_out_inst (
    .clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .motorSpeed, .alarmPresent, .alarmCode, .mainPowerOn,
    .servoEnable, .absDataRequest, .absDataSent, .overloadWarn,
    .regenOverloadWarn, .outCircuit_n, .codeLineOne_n, .codeLineTwo_n,
    .codeLineThree_n, .statusRunning, .runningMonitorItem);
  sso_host_model sso_host_model_inst (.clk_sys, .wantAbs, .outCircuit_n,
    .codeLineOne_n, .codeLineTwo_n, .codeLineThree_n, .absDataRequest,
    .circuitOn, .codeOn);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic close_out;
    if (errTotal == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  // one apb transfer; the expected {error, data} is noted first
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] exp);
    @(posedge clk_sys);
    notes.push_back('{1'b0, exp});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // snapshot of indications and interlocks as the host sees them
  task automatic peek(input logic [7:0] exp);
    @(posedge clk_sys);
    notes.push_back('{1'b1, {25'h0, exp}});
    look <= 1'b1;
    @(posedge clk_sys);
    look <= 1'b0;
  endtask : peek
  // oldest note against each answer or snapshot
  always @(posedge clk_sys) begin
    if ((psel && penable && pready) === 1'b1 || look === 1'b1) begin
      got = look ? {25'h0, statusRunning, runningMonitorItem, codeOn,
                    circuitOn} : {pslverr, prdata};
      nt = notes.pop_front();
      compares++;
      if (got !== nt.val || nt.look !== look) begin
        errTotal++;
        $display("MISMATCH %s expected %h seen %h", look ? "flags" : "apb",
                 nt.val, got);
      end
    end
  end
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    errTotal++;
    close_out();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, motorSpeed, alarmPresent,
     alarmCode, mainPowerOn, servoEnable, absDataSent, overloadWarn,
     regenOverloadWarn, wantAbs, look} = '0;
    reset = 1'b1;
    rng = 32'h988CE025;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    apb(0, ROT_LEVEL_OFS, 0, {19'h0, ROT_LEVEL_RST});
    apb(0, OUT_SEL1_OFS, 0, {17'h0, OUT_SEL1_RST});
    apb(0, OUT_SEL2_OFS, 0, {17'h0, OUT_SEL2_RST});
    apb(0, CODE_CFG_OFS, 0, 33'h0);
    apb(0, STATUS_OFS, 0, 33'h0);
    apb(0, 8'h14, 0, {1'b1, 32'h0});
    apb(1, STATUS_OFS, 32'h3F, {1'b1, 32'h0});
    apb(1, ROT_LEVEL_OFS, 0, {1'b1, 32'h0});
    apb(1, ROT_LEVEL_OFS, 32'h2711, {1'b1, 32'h0});
    apb(1, ROT_LEVEL_OFS, 32'h2710, 33'h0);
    apb(0, ROT_LEVEL_OFS, 0, 33'h2710);
    apb(1, ROT_LEVEL_OFS, 32'h1, 33'h0);
    apb(0, ROT_LEVEL_OFS, 0, 33'h1);
    apb(1, ROT_LEVEL_OFS, 32'h14, 33'h0);
    // warning digits 0 to 4, 8 and 12, every code select and encoder mode, random drive state
    for (int m = 0; m < 16; m++) begin
      // digit 0 alternates with 4, 8 and 12, which also route nowhere
      apb(1, OUT_SEL2_OFS, {16'h0, ((m[1:0] == 2'b00) ? m[3:2] : 2'b00),
          m[1:0], 12'h0}, 33'h0);
      apb(1, CODE_CFG_OFS, {30'h0, m[3], m[2]}, 33'h0);
      repeat (6) begin
        rng = xs(rng);
        @(posedge clk_sys);
        motorSpeed <= rng[0] ? (rng[1] ? 16'hFFEB : 16'h0015) : 16'h0014;
        mainPowerOn <= rng[2];
        servoEnable <= rng[3];
        alarmPresent <= rng[4];
        alarmCode <= rng[7:5];
        overloadWarn <= rng[8];
        regenOverloadWarn <= rng[9];
        absDataSent <= rng[10];
        wantAbs <= rng[11];
        repeat (CTRL + 6) @(posedge clk_sys);
        run = rng[0];
        rdy = rng[2] & rng[3] & !rng[4] & (!m[3] | (rng[10] & rng[11]));
        warn = rng[8] | rng[9];
        for (int i = 0; i < 3; i++)
          on[i] = (run && i == 1) || (rdy && i == 2) ||
                  (warn && m[1:0] == i + 1);
        code = rng[4] ? rng[7:5] : !m[2] ? CODE_NONE :
               rng[8] ? CODE_OVERLOAD : rng[9] ? CODE_REGEN : CODE_NONE;
        peek({run, run, code, on});
        apb(0, STATUS_OFS, 0, {27'h0, on, warn, rdy, run});
      end
    end
    // mid-run reset with the alarm idle: settings fall back to defaults
    alarmPresent <= 1'b0;
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    apb(0, OUT_SEL2_OFS, 0, {17'h0, OUT_SEL2_RST});
    apb(0, CODE_CFG_OFS, 0, 33'h0);
    @(posedge clk_sys);
    close_out();
  end
endmodule : sso_status_out_test
